// file: verilog/cecs_error_state.sv
/*
 * CAN error capture and fault confinement state block with a classic
 * Wishbone register slave and one level interrupt.
 * assumes the protocol engine on the same clock gives one-cycle pulses for
 * detected errors, good frames and lost messages.
 */
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "cecs_map.svh"

module cecs_error_state
   import cecs_pkg::*;
#(
   parameter int CNT_WIDTH = 9,
   parameter int LOST_WIDTH = 16
) (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   // ****************************************
   // wishbone slave
   // ****************************************
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // ****************************************
   // protocol engine events
   // ****************************************
   input wire logic err_det_in,
   input wire logic [1:0] err_type_in,
   input wire logic err_rx_in,
   input wire logic [4:0] err_seg_in,
   input wire logic tx_ok_in,
   input wire logic rx_ok_in,
   input wire logic msg_lost_in,
   // ****************************************
   // bus side controls and interrupt
   // ****************************************
   output logic ack_enable_out,
   output logic err_flag_enable_out,
   output logic err_passive_out,
   output logic irq_out
);

   logic [7:0] err_code;
   logic code_valid;
   logic [7:0] warn_limit;
   logic [LOST_WIDTH-1:0] lost_cnt;
   logic [`CECS_IRQ_WIDTH-1:0] irq_status;
   logic [`CECS_IRQ_WIDTH-1:0] irq_mask;
   logic [`CECS_IRQ_WIDTH-1:0] irq_set;
   logic [CNT_WIDTH-1:0] rx_cnt;
   logic [CNT_WIDTH-1:0] tx_cnt;
   logic cnt_clear;
   cecs_state_type state;
   logic warn;
   logic next_warn;
   logic next_passive;
   logic req;
   logic wr_req;
   logic rd_req;
   logic [31:0] next_rdata;
   logic [7:0] status_byte;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;

   // ****************************************
   // bus access decode
   // ****************************************
   assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
   assign wr_req = req && wb_we_in && wb_sel_in[0];
   assign rd_req = req && !wb_we_in;

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wb_ack_out <= 1'b0;
      end else begin
         wb_ack_out <= req;
      end
   end

   // ****************************************
   // error code capture
   // ****************************************
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         err_code <= 8'h00;
         code_valid <= 1'b0;
      end else if (err_det_in && !code_valid) begin
         err_code[`CECS_TYPE_MSB:`CECS_TYPE_LSB] <= err_type_in;
         err_code[`CECS_DIR_BIT] <= err_rx_in;
         err_code[`CECS_POS_MSB:`CECS_POS_LSB] <= err_seg_in;
         code_valid <= 1'b1;
      end else if (rd_req && (wb_adr_in == `CECS_ERR_CODE_OFS)) begin
         code_valid <= 1'b0;
      end
   end

   // ****************************************
   // error counters
   // ****************************************
   assign cnt_clear = wr_req && (wb_adr_in == `CECS_CONTROL_OFS) && wb_dat_in[`CECS_CTL_CNT_CLEAR];

   cecs_err_counter #(
      .WIDTH(CNT_WIDTH)
   ) u_rx_cnt (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .clear_in(cnt_clear),
      .inc_in(err_det_in && err_rx_in),
      .inc_step_in(4'h1),
      .dec_in(rx_ok_in),
      .count_out(rx_cnt)
   );

   cecs_err_counter #(
      .WIDTH(CNT_WIDTH)
   ) u_tx_cnt (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .clear_in(cnt_clear),
      .inc_in(err_det_in && !err_rx_in),
      .inc_step_in(4'h8),
      .dec_in(tx_ok_in),
      .count_out(tx_cnt)
   );

   // ****************************************
   // warning limit and fault confinement
   // ****************************************
   assign next_warn = ({1'b0, rx_cnt} > {{(CNT_WIDTH - 7){1'b0}}, warn_limit})
      || ({1'b0, tx_cnt} > {{(CNT_WIDTH - 7){1'b0}}, warn_limit});
   assign next_passive = (rx_cnt >= CNT_WIDTH'(`CECS_PASSIVE_LEVEL))
      || (tx_cnt >= CNT_WIDTH'(`CECS_PASSIVE_LEVEL));

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         warn <= 1'b0;
      end else begin
         warn <= next_warn;
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= CECS_ST_ACTIVE;
      end else begin
         case (state)
            CECS_ST_ACTIVE: begin
               if (next_passive) begin
                  state <= CECS_ST_PASSIVE;
               end
            end
            CECS_ST_PASSIVE: begin
               if (!next_passive) begin
                  state <= CECS_ST_ACTIVE;
               end
            end
            default: begin
               state <= CECS_ST_ACTIVE;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ack_enable_out <= 1'b1;
         err_flag_enable_out <= 1'b1;
         err_passive_out <= 1'b0;
      end else begin
         ack_enable_out <= !next_passive;
         err_flag_enable_out <= !next_passive;
         err_passive_out <= next_passive;
      end
   end

   // ****************************************
   // lost message counter
   // ****************************************
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         lost_cnt <= '0;
      end else if (msg_lost_in && (lost_cnt != '1)) begin
         lost_cnt <= lost_cnt + 1'b1;
      end else if (wr_req && (wb_adr_in == `CECS_LOST_CNT_OFS)) begin
         lost_cnt <= '0;
      end
   end

   // ****************************************
   // interrupt status, mask and output
   // ****************************************
   always_comb begin
      irq_set = '0;
      irq_set[`CECS_IRQ_ERROR] = err_det_in;
      irq_set[`CECS_IRQ_WARN] = next_warn && !warn;
      irq_set[`CECS_IRQ_RECOVER] = !next_warn && warn;
      irq_set[`CECS_IRQ_PASSIVE] = next_passive && (state == CECS_ST_ACTIVE);
      irq_set[`CECS_IRQ_ACTIVE] = !next_passive && (state == CECS_ST_PASSIVE);
      irq_set[`CECS_IRQ_LOST] = msg_lost_in;
   end

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         irq_status <= '0;
      end else if (wr_req && (wb_adr_in == `CECS_IRQ_STATUS_OFS)) begin
         irq_status <= (irq_status & ~wb_dat_in[`CECS_IRQ_WIDTH-1:0]) | irq_set;
      end else begin
         irq_status <= irq_status | irq_set;
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         irq_mask <= '0;
         warn_limit <= `CECS_WARN_LIMIT_RST;
      end else if (wr_req) begin
         if (wb_adr_in == `CECS_IRQ_MASK_OFS) begin
            irq_mask <= wb_dat_in[`CECS_IRQ_WIDTH-1:0];
         end
         if (wb_adr_in == `CECS_WARN_LIMIT_OFS) begin
            warn_limit <= wb_dat_in[7:0];
         end
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |((irq_status | irq_set) & irq_mask);
      end
   end

   // ****************************************
   // read data
   // ****************************************
   assign rx_byte = (rx_cnt > CNT_WIDTH'(8'hFF)) ? 8'hFF : rx_cnt[7:0];
   assign tx_byte = (tx_cnt > CNT_WIDTH'(8'hFF)) ? 8'hFF : tx_cnt[7:0];

   always_comb begin
      status_byte = 8'h00;
      status_byte[`CECS_ST_WARN_BIT] = warn;
      status_byte[`CECS_ST_PASSIVE_BIT] = (state == CECS_ST_PASSIVE);
      status_byte[`CECS_ST_CODE_VALID] = code_valid;
      status_byte[`CECS_ST_BUSOFF_BIT] = (tx_cnt >= CNT_WIDTH'(`CECS_BUSOFF_LEVEL));
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (wb_adr_in)
         `CECS_ERR_CODE_OFS: next_rdata[7:0] = err_code;
         `CECS_STATUS_OFS: next_rdata[7:0] = status_byte;
         `CECS_RX_ERR_CNT_OFS: next_rdata[7:0] = rx_byte;
         `CECS_TX_ERR_CNT_OFS: next_rdata[7:0] = tx_byte;
         `CECS_WARN_LIMIT_OFS: next_rdata[7:0] = warn_limit;
         `CECS_LOST_CNT_OFS: next_rdata[LOST_WIDTH-1:0] = lost_cnt;
         `CECS_IRQ_STATUS_OFS: next_rdata[`CECS_IRQ_WIDTH-1:0] = irq_status;
         `CECS_IRQ_MASK_OFS: next_rdata[`CECS_IRQ_WIDTH-1:0] = irq_mask;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wb_dat_out <= 32'h0000_0000;
      end else if (rd_req) begin
         wb_dat_out <= next_rdata;
      end
   end

endmodule // cecs_error_state

`default_nettype wire

// file: verilog/cecs_map.svh
/*
 * register offsets, field positions, reset values and thresholds of the
 * CAN error capture and state block.
 * assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
`ifndef CECS_MAP_SVH
`define CECS_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define CECS_ERR_CODE_OFS    8'h00
`define CECS_STATUS_OFS      8'h04
`define CECS_RX_ERR_CNT_OFS  8'h08
`define CECS_TX_ERR_CNT_OFS  8'h0C
`define CECS_WARN_LIMIT_OFS  8'h10
`define CECS_LOST_CNT_OFS    8'h14
`define CECS_IRQ_STATUS_OFS  8'h18
`define CECS_IRQ_MASK_OFS    8'h1C
`define CECS_CONTROL_OFS     8'h20

// ****************************************
// error code fields
// ****************************************
`define CECS_TYPE_MSB        7
`define CECS_TYPE_LSB        6
`define CECS_DIR_BIT         5
`define CECS_POS_MSB         4
`define CECS_POS_LSB         0

// ****************************************
// status register bits
// ****************************************
`define CECS_ST_WARN_BIT     0
`define CECS_ST_PASSIVE_BIT  1
`define CECS_ST_CODE_VALID   2
`define CECS_ST_BUSOFF_BIT   3

// ****************************************
// interrupt status bits
// ****************************************
`define CECS_IRQ_ERROR       0
`define CECS_IRQ_WARN        1
`define CECS_IRQ_PASSIVE     2
`define CECS_IRQ_RECOVER     3
`define CECS_IRQ_ACTIVE      4
`define CECS_IRQ_LOST        5
`define CECS_IRQ_WIDTH       6

// ****************************************
// control register bits
// ****************************************
`define CECS_CTL_CNT_CLEAR   0

// ****************************************
// reset values and thresholds
// ****************************************
`define CECS_WARN_LIMIT_RST  8'h60
`define CECS_PASSIVE_LEVEL   9'h080
`define CECS_BUSOFF_LEVEL    9'h100
`define CECS_CNT_RST         9'h000

`endif

// file: verilog/cecs_pkg.sv
/*
 * types of the CAN error capture and state block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package cecs_pkg;

   // ****************************************
   // error types
   // ****************************************
   typedef enum logic [1:0] {
      CECS_ERR_BIT    = 2'b00,
      CECS_ERR_FORMAT = 2'b01,
      CECS_ERR_STUFF  = 2'b10,
      CECS_ERR_OTHER  = 2'b11
   } cecs_err_type;

   // ****************************************
   // frame segment where the error fell
   // ****************************************
   typedef enum logic [4:0] {
      CECS_SEG_SOF       = 5'h03,
      CECS_SEG_ID_28_21  = 5'h02,
      CECS_SEG_ID_20_18  = 5'h06,
      CECS_SEG_SRTR      = 5'h04,
      CECS_SEG_IDE       = 5'h05,
      CECS_SEG_ID_17_13  = 5'h07,
      CECS_SEG_ID_12_5   = 5'h0F,
      CECS_SEG_ID_4_0    = 5'h0E,
      CECS_SEG_RTR       = 5'h0C,
      CECS_SEG_RSV1      = 5'h0D,
      CECS_SEG_RSV0      = 5'h09,
      CECS_SEG_DLC       = 5'h0B,
      CECS_SEG_DATA      = 5'h0A,
      CECS_SEG_CRC       = 5'h08,
      CECS_SEG_CRC_DELIM = 5'h18,
      CECS_SEG_ACK_SLOT  = 5'h19,
      CECS_SEG_ACK_DELIM = 5'h1B,
      CECS_SEG_EOF       = 5'h1A,
      CECS_SEG_INTERMISS = 5'h12,
      CECS_SEG_ACT_FLAG  = 5'h11,
      CECS_SEG_PAS_FLAG  = 5'h16,
      CECS_SEG_TOL_DOM   = 5'h13,
      CECS_SEG_ERR_DELIM = 5'h17,
      CECS_SEG_OVL_FLAG  = 5'h1C
   } cecs_seg_type;

   // ****************************************
   // fault confinement states
   // ****************************************
   typedef enum logic [1:0] {
      CECS_ST_ACTIVE  = 2'b00,
      CECS_ST_PASSIVE = 2'b01
   } cecs_state_type;

endpackage : cecs_pkg

`default_nettype wire

// file: verilog/cecs_err_counter.sv
/*
 * one CAN error counter: adds a step on an error, subtracts one on a good
 * frame, saturates at both ends and clears on request.
 * assumes increment, decrement and clear are pulses on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module cecs_err_counter #(
   parameter int WIDTH = 9
) (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic clear_in,
   input wire logic inc_in,
   input wire logic [3:0] inc_step_in,
   input wire logic dec_in,
   output logic [WIDTH-1:0] count_out
);

   logic [WIDTH:0] sum;

   assign sum = {1'b0, count_out} + {{(WIDTH - 3){1'b0}}, inc_step_in};

   // saturating add and subtract
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         count_out <= '0;
      end else if (clear_in) begin
         count_out <= '0;
      end else if (inc_in) begin
         count_out <= sum[WIDTH] ? '1 : sum[WIDTH-1:0];
      end else if (dec_in && (count_out != '0)) begin
         count_out <= count_out - 1'b1;
      end
   end

endmodule // cecs_err_counter

`default_nettype wire

// file: verification/cecs_error_state_monitor.sv
/* port checker of the error capture and state block.
   assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/10ps
`default_nettype none
// **********
// checker
// **********
module cecs_error_state_monitor (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic err_det_in,
   input wire logic tx_ok_in,
   input wire logic rx_ok_in,
   input wire logic ack_enable_out,
   input wire logic err_flag_enable_out,
   input wire logic err_passive_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   property p_ack_next;
      wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_pulse;
      wb_ack_out |=> !wb_ack_out;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
   property p_hi_zero;
      wb_ack_out |-> wb_dat_out[31:16] == 16'h0;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("upper data set");
   property p_unmapped;
      wb_ack_out && !$past(wb_we_in) && $past(wb_adr_in) > 8'h20 |-> wb_dat_out == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped data");
   property p_pas_ack;
      err_passive_out |-> !ack_enable_out;
   endproperty
   a_pas_ack: assert property (p_pas_ack) else $error("ack while passive");
   property p_pas_flag;
      err_passive_out |-> !err_flag_enable_out;
   endproperty
   a_pas_flag: assert property (p_pas_flag) else $error("flag while passive");
   property p_act_en;
      !err_passive_out |-> ack_enable_out && err_flag_enable_out;
   endproperty
   a_act_en: assert property (p_act_en) else $error("active disabled");
   property p_pas_rise;
      $rose(err_passive_out) |-> $past(err_det_in, 2);
   endproperty
   a_pas_rise: assert property (p_pas_rise) else $error("passive no error");
   property p_pas_fall;
      $fell(err_passive_out) |-> $past(tx_ok_in, 2) || $past(rx_ok_in, 2) || $past(wb_we_in, 2);
   endproperty
   a_pas_fall: assert property (p_pas_fall) else $error("active no cause");
endmodule // cecs_error_state_monitor

bind cecs_error_state cecs_error_state_monitor mon (.clock_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in,
   .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out, .err_det_in, .tx_ok_in, .rx_ok_in,
   .ack_enable_out, .err_flag_enable_out, .err_passive_out);
`default_nettype wire

// file: verification/cecs_can_node_model.sv
/* far-side node: makes error, good frame and lost events.
   assumes each task is entered just after a rising clock edge. */
`timescale 1ns/10ps
`default_nettype none
// **********
// node model
// **********
module cecs_can_node_model (
   input wire logic clock_in,
   output logic err_det_out,
   output logic [1:0] err_type_out,
   output logic err_rx_out,
   output logic [4:0] err_seg_out,
   output logic tx_ok_out,
   output logic rx_ok_out,
   output logic lost_out
);
   initial begin
      err_det_out = 1'b0;
      err_type_out = 2'h0;
      err_rx_out = 1'b0;
      err_seg_out = 5'h00;
      tx_ok_out = 1'b0;
      rx_ok_out = 1'b0;
      lost_out = 1'b0;
   end
   // fields go to the inverse once the pulse ends
   task automatic bus_error(input logic [1:0] t, input logic rx, input logic [4:0] s);
      err_det_out <= 1'b1;
      err_type_out <= t;
      err_rx_out <= rx;
      err_seg_out <= s;
      @(posedge clock_in);
      err_det_out <= 1'b0;
      err_type_out <= ~t;
      err_rx_out <= ~rx;
      err_seg_out <= ~s;
      @(posedge clock_in);
   endtask
   task automatic good_frame(input logic rx);
      rx_ok_out <= rx;
      tx_ok_out <= ~rx;
      @(posedge clock_in);
      rx_ok_out <= 1'b0;
      tx_ok_out <= 1'b0;
      @(posedge clock_in);
   endtask
   task automatic lost();
      lost_out <= 1'b1;
      @(posedge clock_in);
      lost_out <= 1'b0;
      @(posedge clock_in);
   endtask
endmodule // cecs_can_node_model
`default_nettype wire

// file: verification/cecs_error_state_tb_top.sv
/* self-checking bench of the error capture and state block.
   assumes the node model and checker are compiled before it. */
`timescale 1ns/10ps
`default_nettype none
`include "cecs_map.svh"
// **********
// bench
// **********
module cecs_error_state_tb_top;
   import cecs_pkg::*;
   localparam logic [7:0] ST = `CECS_STATUS_OFS;
   localparam logic [7:0] TX = `CECS_TX_ERR_CNT_OFS;
   localparam logic [7:0] IS = `CECS_IRQ_STATUS_OFS;
   localparam logic [7:0] CT = `CECS_CONTROL_OFS;
   localparam logic [7:0] LIM = `CECS_WARN_LIMIT_OFS;
   logic clock_in, sys_rst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
   logic [7:0] wb_adr_in;
   logic [3:0] wb_sel_in;
   logic [31:0] wb_dat_in, wb_dat_out, rd;
   logic err_det_in, err_rx_in, tx_ok_in, rx_ok_in, msg_lost_in;
   logic [1:0] err_type_in;
   logic [4:0] err_seg_in;
   logic ack_enable_out, err_flag_enable_out, err_passive_out, irq_out;
   int bad_count, check_count, cycles;
   logic [4:0] segs [4] = '{CECS_SEG_SOF, CECS_SEG_ACK_SLOT, CECS_SEG_EOF, CECS_SEG_OVL_FLAG};
   cecs_error_state uut (.clock_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
      .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .err_det_in, .err_type_in, .err_rx_in,
      .err_seg_in, .tx_ok_in, .rx_ok_in, .msg_lost_in, .ack_enable_out, .err_flag_enable_out,
      .err_passive_out, .irq_out);
   cecs_can_node_model node (.clock_in, .err_det_out(err_det_in), .err_type_out(err_type_in),
      .err_rx_out(err_rx_in), .err_seg_out(err_seg_in), .tx_ok_out(tx_ok_in),
      .rx_ok_out(rx_ok_in), .lost_out(msg_lost_in));
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         give_verdict();
      end
   end
   task automatic check(input string name, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // ack is read before the edge updates land, so it is the sampled value
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= we;
      wb_adr_in <= a;
      wb_dat_in <= d;
      @(posedge clock_in);
      while (wb_ack_out !== 1'b1) @(posedge clock_in);
      rd = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      @(posedge clock_in);
   endtask
   task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      check(name, rd, exp);
   endtask
   task automatic settle();
      repeat (3) @(posedge clock_in);
   endtask
   initial begin
      sys_rst_in = 1'b1;
      {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} = '0;
      wb_sel_in = 4'hF;
      repeat (4) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      @(posedge clock_in);
      rdchk("limit", LIM, 32'h60);
      rdchk("tx", TX, 32'h0);
      rdchk("status", ST, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         node.bus_error(i[1:0], i[0], segs[i]);
         if (i == 0) node.bus_error(2'h3, 1'b1, CECS_SEG_DATA);
         rdchk("code", `CECS_ERR_CODE_OFS, {24'h0, i[1:0], i[0], segs[i]});
      end
      rdchk("rx", `CECS_RX_ERR_CNT_OFS, 32'h3);
      rdchk("tx", TX, 32'h10);
      $display("test capture done");
      // clear counts before lowering the limit, so no warn or recover event is left pending
      wb(1'b1, CT, 32'h1);
      wb(1'b1, LIM, 32'h2);
      wb(1'b1, IS, 32'h3F);
      wb(1'b1, `CECS_IRQ_MASK_OFS, 32'h0A);
      repeat (2) node.bus_error(2'h0, 1'b1, CECS_SEG_DATA);
      settle();
      check("irq at limit", 32'(irq_out), 32'h0);
      node.bus_error(2'h0, 1'b1, CECS_SEG_DATA);
      settle();
      check("irq warn", 32'(irq_out), 32'h1);
      rdchk("st warn", ST, 32'h5);
      wb(1'b1, IS, 32'h3F);
      check("irq clr", 32'(irq_out), 32'h0);
      node.good_frame(1'b1);
      settle();
      check("irq rec", 32'(irq_out), 32'h1);
      rdchk("is rec", IS, 32'h08);
      rdchk("st rec", ST, 32'h4);
      $display("test warning done");
      wb(1'b1, CT, 32'h1);
      wb(1'b1, LIM, 32'hFF);
      wb(1'b1, IS, 32'h3F);
      repeat (15) node.bus_error(2'h1, 1'b0, CECS_SEG_ACK_DELIM);
      settle();
      check("pas 120", 32'(err_passive_out), 32'h0);
      node.bus_error(2'h1, 1'b0, CECS_SEG_ACK_DELIM);
      settle();
      check("pas", 32'(err_passive_out), 32'h1);
      check("ack en", 32'(ack_enable_out), 32'h0);
      check("flag en", 32'(err_flag_enable_out), 32'h0);
      rdchk("tx 128", TX, 32'h80);
      rdchk("st pas", ST, 32'h6);
      node.good_frame(1'b0);
      settle();
      check("act", 32'(err_passive_out), 32'h0);
      check("flag act", 32'(err_flag_enable_out), 32'h1);
      check("ack act", 32'(ack_enable_out), 32'h1);
      rdchk("is act", IS, 32'h15);
      $display("test passive done");
      repeat (3) node.lost();
      settle();
      rdchk("lost", `CECS_LOST_CNT_OFS, 32'h3);
      check("irq masked", 32'(irq_out), 32'h0);
      wb(1'b1, `CECS_IRQ_MASK_OFS, 32'h20);
      check("irq lost", 32'(irq_out), 32'h1);
      wb(1'b1, `CECS_LOST_CNT_OFS, 32'h0);
      rdchk("lost clr", `CECS_LOST_CNT_OFS, 32'h0);
      wb(1'b1, IS, 32'h20);
      check("irq off", 32'(irq_out), 32'h0);
      rdchk("unmapped", 8'h40, 32'h0);
      $display("test lost done");
      give_verdict();
   end
endmodule // cecs_error_state_tb_top
`default_nettype wire
